// [pit_pkg.sv]
package pit_pkg;

    // address bit positions within the seven-bit register address
    localparam int ADDR_W          = 7;
    localparam int BIT_SEL_LOW     = 0;   // port register pick, prescale pick, edge polarity
    localparam int BIT_SEL_HIGH    = 1;   // port register pick, prescale pick, edge interrupt enable
    localparam int BIT_TIMER_AREA  = 2;   // high: timer, flags and edge control
    localparam int BIT_TIMER_IRQ   = 3;   // timer interrupt enable, latched on every timer access
    localparam int BIT_TIMER_WRITE = 4;   // high: timer load, low: edge control

    // port register picks on the two low address bits
    localparam logic [1:0] SEL_PORT_A_OUT = 2'h0;
    localparam logic [1:0] SEL_PORT_A_DIR = 2'h1;
    localparam logic [1:0] SEL_PORT_B_OUT = 2'h2;
    localparam logic [1:0] SEL_PORT_B_DIR = 2'h3;

    // prescale picks and the reload value of the divide-down counter
    localparam int          PRESCALE_W      = 10;
    localparam logic [1:0]  SEL_DIV_1       = 2'h0;
    localparam logic [1:0]  SEL_DIV_8       = 2'h1;
    localparam logic [1:0]  SEL_DIV_64      = 2'h2;
    localparam logic [1:0]  SEL_DIV_1024    = 2'h3;
    localparam logic [9:0]  RELOAD_DIV_1    = 10'h000;
    localparam logic [9:0]  RELOAD_DIV_8    = 10'h007;
    localparam logic [9:0]  RELOAD_DIV_64   = 10'h03f;
    localparam logic [9:0]  RELOAD_DIV_1024 = 10'h3ff;

    // flag register layout
    localparam int FLAG_TIMER_BIT = 7;
    localparam int FLAG_EDGE_BIT  = 6;

    // counter values
    localparam logic [7:0] COUNT_ZERO    = 8'h00;
    localparam logic [7:0] COUNT_TIMEOUT = 8'hff;  // minus one after timeout
    localparam logic [7:0] COUNT_LIMIT   = 8'h01;  // minus 255, elapsed count stops here
    localparam logic [7:0] COUNT_RESET   = 8'h01;  // parked at the limit, no timeout pending

    // reset values
    localparam logic [7:0] PORT_RESET  = 8'h00;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic       EDGE_POS_RESET = 1'b0;  // negative edge after reset

    // timer phases
    typedef enum logic [0:0] {
        TM_COUNT   = 1'b0,   // counting prescaled intervals
        TM_ELAPSED = 1'b1    // past timeout, counting single clocks
    } pit_tmode_e;

endpackage

// [pit_sync.sv]
`timescale 1ns/1ps
// three-stage pin synchroniser; the filtered value follows only once stages two and three agree
module pit_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinSync
);

    logic [W-1:0] st1_q;
    logic [W-1:0] st2_q;
    logic [W-1:0] st3_q;
    logic [W-1:0] filt_q;
    logic [W-1:0] filt_d;

    // per bit: accept a new level only when the two settled stages match
    always_comb begin
        filt_d = filt_q;
        for (int i = 0; i < W; i++) begin
            if (st2_q[i] == st3_q[i]) begin
                filt_d[i] = st3_q[i];
            end
        end
    end

    // stage one feeds stage two and nothing else
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st1_q  <= '0;
            st2_q  <= '0;
            st3_q  <= '0;
            filt_q <= '0;
        end else begin
            st1_q  <= pinIn;
            st2_q  <= st1_q;
            st3_q  <= st2_q;
            filt_q <= filt_d;
        end
    end

    assign pinSync = filt_q;

endmodule

// [pit_ram.sv]
`timescale 1ns/1ps
// scratch memory; read is combinational so the caller can register it with the register reads
module pit_ram #(
    parameter int DEPTH  = 128,
    parameter int ADDR_W = 7
) (
    input  wire logic              sys_clk,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wrData,
    output logic      [7:0]        rdData
);

    logic [7:0] mem [DEPTH];

    // contents are not cleared by reset, as for a static memory
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
    end

    assign rdData = mem[addr];

endmodule

// [pit_top.sv]
`timescale 1ns/1ps
// What this block does
// - four 8-bit port registers; direction bit one drives the line out
// - output lines carry the matching output register bit
// - reading port A output register returns sampled pin levels
// - reading port B output register returns stored bits on output lines
// - timer write loads count; interval is 1, 8, 64 or 1024 clocks
// - on timer write address bits 1..0 choose the prescale
// - timer read before timeout returns intervals still remaining
// - step after zero gives all ones and sets the timer flag
// - after timeout count drops every clock, stopping at minus 255
// - timeout sets flag bit 7 even with its interrupt disabled
// - every timer access latches address bit 3 as timer interrupt enable
// - any timer read or write clears the timer flag
// - a timer read in the timeout clock leaves the flag set
// - active edge on port A top line sets flag bit 6, may interrupt
// - edge flag sets whether top line is input or output
// - flag read gives timer bit 7, edge bit 6, clears edge flag
// - write with bit 4 low, bit 2 high sets edge enable and polarity
// - reset disables edge interrupt, picks negative edge, edge may still flag
// - selected by select one high, select two low; register select splits RAM
// - bit 2 low picks port registers by address bits 1..0
// - reset clears port registers and floats the data bus
// - interrupt request is active low and open drain
// - 128-byte RAM on the seven address bits with register select low
module pit_top (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       busStrobe,
    input  wire logic       chipSelectOne,
    input  wire logic       chipSelectTwoN,
    input  wire logic       ramSelectN,
    input  wire logic       readNotWrite,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] dataIn,
    output logic      [7:0] dataOut,
    output logic            dataOe,
    input  wire logic [7:0] portALinesIn,
    output logic      [7:0] portALinesOut,
    output logic      [7:0] portALinesOe,
    input  wire logic [7:0] portBLinesIn,
    output logic      [7:0] portBLinesOut,
    output logic      [7:0] portBLinesOe,
    output logic            irqReqNOut,
    output logic            irqReqNOe
);

    // reload value of the divide-down counter for a prescale pick
    function automatic logic [9:0] prescaleReload(input logic [1:0] sel);
        case (sel)
            pit_pkg::SEL_DIV_1:    prescaleReload = pit_pkg::RELOAD_DIV_1;
            pit_pkg::SEL_DIV_8:    prescaleReload = pit_pkg::RELOAD_DIV_8;
            pit_pkg::SEL_DIV_64:   prescaleReload = pit_pkg::RELOAD_DIV_64;
            pit_pkg::SEL_DIV_1024: prescaleReload = pit_pkg::RELOAD_DIV_1024;
            default:               prescaleReload = pit_pkg::RELOAD_DIV_1;
        endcase
    endfunction

    logic [7:0] portASync;
    logic [7:0] portBSync;
    logic [7:0] ramRdData;

    // port registers
    logic [7:0] portAOut_q;
    logic [7:0] portAOut_d;
    logic [7:0] portADir_q;
    logic [7:0] portADir_d;
    logic [7:0] portBOut_q;
    logic [7:0] portBOut_d;
    logic [7:0] portBDir_q;
    logic [7:0] portBDir_d;

    // timer state
    pit_pkg::pit_tmode_e tmode_q;
    pit_pkg::pit_tmode_e tmode_d;
    logic [7:0]          count_q;
    logic [7:0]          count_d;
    logic [9:0]          pre_q;
    logic [9:0]          pre_d;
    logic [1:0]          preSel_q;
    logic [1:0]          preSel_d;
    logic                timerIrqEn_q;
    logic                timerIrqEn_d;
    logic                timerFlag_q;
    logic                timerFlag_d;
    logic                timeout;

    // edge detector state
    logic edgeIrqEn_q;
    logic edgeIrqEn_d;
    logic edgePos_q;
    logic edgePos_d;
    logic edgeFlag_q;
    logic edgeFlag_d;
    logic topPrev_q;
    logic activeEdge;

    // bus outputs
    logic [7:0] dataOut_q;
    logic [7:0] dataOut_d;
    logic       dataOe_q;
    logic       dataOe_d;
    logic       irqOe_q;
    logic       irqOe_d;

    // pin outputs
    logic [7:0] portAPinOut_q;
    logic [7:0] portAPinOe_q;
    logic [7:0] portBPinOut_q;
    logic [7:0] portBPinOe_q;

    // access decode
    logic selected;
    logic regAccess;
    logic ramWrite;
    logic portAccess;
    logic timerArea;
    logic timerLoad;
    logic edgeCtrlWrite;
    logic timerRead;
    logic flagRead;
    logic portWrite;

    pit_sync #(
        .W(8)
    ) u_sync_a (
        .sys_clk (sys_clk),
        .srst    (srst),
        .pinIn   (portALinesIn),
        .pinSync (portASync)
    );

    pit_sync #(
        .W(8)
    ) u_sync_b (
        .sys_clk (sys_clk),
        .srst    (srst),
        .pinIn   (portBLinesIn),
        .pinSync (portBSync)
    );

    pit_ram #(
        .DEPTH (128),
        .ADDR_W(pit_pkg::ADDR_W)
    ) u_ram (
        .sys_clk (sys_clk),
        .wrEn    (ramWrite),
        .addr    (addr),
        .wrData  (dataIn),
        .rdData  (ramRdData)
    );

    // chip and area selection; one access per strobe
    assign selected      = busStrobe && chipSelectOne && !chipSelectTwoN;
    assign regAccess     = selected && ramSelectN;
    assign ramWrite      = selected && !ramSelectN && !readNotWrite;
    assign timerArea     = regAccess && addr[pit_pkg::BIT_TIMER_AREA];
    assign portAccess    = regAccess && !addr[pit_pkg::BIT_TIMER_AREA];
    assign portWrite     = portAccess && !readNotWrite;
    assign timerLoad     = timerArea && !readNotWrite && addr[pit_pkg::BIT_TIMER_WRITE];
    assign edgeCtrlWrite = timerArea && !readNotWrite && !addr[pit_pkg::BIT_TIMER_WRITE];
    assign timerRead     = timerArea && readNotWrite && !addr[pit_pkg::BIT_SEL_LOW];
    assign flagRead      = timerArea && readNotWrite && addr[pit_pkg::BIT_SEL_LOW];

    // port register writes
    always_comb begin
        portAOut_d = portAOut_q;
        portADir_d = portADir_q;
        portBOut_d = portBOut_q;
        portBDir_d = portBDir_q;
        if (portWrite) begin
            case (addr[1:0])
                pit_pkg::SEL_PORT_A_OUT: portAOut_d = dataIn;
                pit_pkg::SEL_PORT_A_DIR: portADir_d = dataIn;
                pit_pkg::SEL_PORT_B_OUT: portBOut_d = dataIn;
                pit_pkg::SEL_PORT_B_DIR: portBDir_d = dataIn;
                default:                 portAOut_d = portAOut_q;
            endcase
        end
    end

    // timer: the divide-down counter is cleared on load so the first step lands one clock later
    always_comb begin
        tmode_d      = tmode_q;
        count_d      = count_q;
        pre_d        = pre_q;
        preSel_d     = preSel_q;
        timerIrqEn_d = timerIrqEn_q;
        timerFlag_d  = timerFlag_q;
        timeout      = 1'b0;
        case (tmode_q)
            pit_pkg::TM_COUNT: begin
                if (pre_q == 10'h000) begin
                    pre_d = prescaleReload(preSel_q);
                    if (count_q == pit_pkg::COUNT_ZERO) begin
                        count_d = pit_pkg::COUNT_TIMEOUT;
                        tmode_d = pit_pkg::TM_ELAPSED;
                        timeout = 1'b1;
                    end else begin
                        count_d = count_q - 8'h01;
                    end
                end else begin
                    pre_d = pre_q - 10'h001;
                end
            end
            pit_pkg::TM_ELAPSED: begin
                if (count_q != pit_pkg::COUNT_LIMIT) begin
                    count_d = count_q - 8'h01;
                end
            end
            default: tmode_d = pit_pkg::TM_COUNT;
        endcase
        if (timerLoad || timerRead) begin
            timerIrqEn_d = addr[pit_pkg::BIT_TIMER_IRQ];
            timerFlag_d  = 1'b0;
        end
        if (timerLoad) begin
            count_d  = dataIn;
            preSel_d = addr[1:0];
            pre_d    = 10'h000;
            tmode_d  = pit_pkg::TM_COUNT;
        end
        // a timeout in the same clock as a read wins over the clear
        if (timeout && !timerLoad) begin
            timerFlag_d = 1'b1;
        end
    end

    // edge detector works on the synchronised top line whatever its direction
    assign activeEdge = edgePos_q ? (!topPrev_q && portASync[7]) : (topPrev_q && !portASync[7]);

    always_comb begin
        edgeIrqEn_d = edgeIrqEn_q;
        edgePos_d   = edgePos_q;
        edgeFlag_d  = edgeFlag_q;
        if (flagRead) begin
            edgeFlag_d = 1'b0;
        end
        if (activeEdge) begin
            edgeFlag_d = 1'b1;
        end
        if (edgeCtrlWrite) begin
            edgeIrqEn_d = addr[pit_pkg::BIT_SEL_HIGH];
            edgePos_d   = addr[pit_pkg::BIT_SEL_LOW];
        end
    end

    // read data and request line; both registered so the pins come straight from flops
    always_comb begin
        dataOut_d = pit_pkg::BYTE_ZERO;
        dataOe_d  = 1'b0;
        if (selected && readNotWrite) begin
            dataOe_d = 1'b1;
            if (!ramSelectN) begin
                dataOut_d = ramRdData;
            end else if (!addr[pit_pkg::BIT_TIMER_AREA]) begin
                case (addr[1:0])
                    pit_pkg::SEL_PORT_A_OUT: dataOut_d = portASync;
                    pit_pkg::SEL_PORT_A_DIR: dataOut_d = portADir_q;
                    pit_pkg::SEL_PORT_B_OUT: dataOut_d = (portBOut_q & portBDir_q) | (portBSync & ~portBDir_q);
                    pit_pkg::SEL_PORT_B_DIR: dataOut_d = portBDir_q;
                    default:                 dataOut_d = pit_pkg::BYTE_ZERO;
                endcase
            end else if (addr[pit_pkg::BIT_SEL_LOW]) begin
                dataOut_d[pit_pkg::FLAG_TIMER_BIT] = timerFlag_q;
                dataOut_d[pit_pkg::FLAG_EDGE_BIT]  = edgeFlag_q;
            end else begin
                dataOut_d = count_q;
            end
        end
        // pulls low only; the shared line is high when nobody pulls
        irqOe_d = (timerFlag_d && timerIrqEn_d) || (edgeFlag_d && edgeIrqEn_d);
    end

    // register stage for all control state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            portAOut_q    <= pit_pkg::PORT_RESET;
            portADir_q    <= pit_pkg::PORT_RESET;
            portBOut_q    <= pit_pkg::PORT_RESET;
            portBDir_q    <= pit_pkg::PORT_RESET;
            tmode_q       <= pit_pkg::TM_ELAPSED;
            count_q       <= pit_pkg::COUNT_RESET;
            pre_q         <= pit_pkg::RELOAD_DIV_1;
            preSel_q      <= pit_pkg::SEL_DIV_1;
            timerIrqEn_q  <= 1'b0;
            timerFlag_q   <= 1'b0;
            edgeIrqEn_q   <= 1'b0;
            edgePos_q     <= pit_pkg::EDGE_POS_RESET;
            // a falling top line during reset may still leave the edge flag set
            edgeFlag_q    <= topPrev_q && !portASync[7];
            topPrev_q     <= portASync[7];
            dataOut_q     <= pit_pkg::BYTE_ZERO;
            dataOe_q      <= 1'b0;
            irqOe_q       <= 1'b0;
            portAPinOut_q <= pit_pkg::PORT_RESET;
            portAPinOe_q  <= pit_pkg::PORT_RESET;
            portBPinOut_q <= pit_pkg::PORT_RESET;
            portBPinOe_q  <= pit_pkg::PORT_RESET;
        end else begin
            portAOut_q    <= portAOut_d;
            portADir_q    <= portADir_d;
            portBOut_q    <= portBOut_d;
            portBDir_q    <= portBDir_d;
            tmode_q       <= tmode_d;
            count_q       <= count_d;
            pre_q         <= pre_d;
            preSel_q      <= preSel_d;
            timerIrqEn_q  <= timerIrqEn_d;
            timerFlag_q   <= timerFlag_d;
            edgeIrqEn_q   <= edgeIrqEn_d;
            edgePos_q     <= edgePos_d;
            edgeFlag_q    <= edgeFlag_d;
            topPrev_q     <= portASync[7];
            dataOut_q     <= dataOut_d;
            dataOe_q      <= dataOe_d;
            irqOe_q       <= irqOe_d;
            portAPinOut_q <= portAOut_d;
            portAPinOe_q  <= portADir_d;
            portBPinOut_q <= portBOut_d;
            portBPinOe_q  <= portBDir_d;
        end
    end

    assign dataOut       = dataOut_q;
    assign dataOe        = dataOe_q;
    assign portALinesOut = portAPinOut_q;
    assign portALinesOe  = portAPinOe_q;
    assign portBLinesOut = portBPinOut_q;
    assign portBLinesOe  = portBPinOe_q;
    assign irqReqNOe     = irqOe_q;
    assign irqReqNOut    = 1'b0;   // open drain: only ever pulls low

endmodule

// [pit_asserts.sv]
`timescale 1ns/1ps
// bus answers, port registers and reset state seen at the top ports
module pit_asserts (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       busStrobe,
    input wire logic       chipSelectOne,
    input wire logic       chipSelectTwoN,
    input wire logic       ramSelectN,
    input wire logic       readNotWrite,
    input wire logic [6:0] addr,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] dataOut,
    input wire logic       dataOe,
    input wire logic [7:0] portALinesOe,
    input wire logic [7:0] portBLinesOut,
    input wire logic [7:0] portBLinesOe,
    input wire logic       irqReqNOut,
    input wire logic       irqReqNOe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // a taken access, and a write into the port register area
    wire acc   = busStrobe & chipSelectOne & !chipSelectTwoN;
    wire regWr = acc & ramSelectN & !readNotWrite & !addr[2];

    read_answer_a: assert property (acc && readNotWrite |=> dataOe)
        else $error("read was not answered");
    idle_quiet_a: assert property (!acc |=> !dataOe && dataOut == 8'h00)
        else $error("data driven without an access");
    reset_state_a: assert property (disable iff (1'b0) srst |=> !dataOe && portALinesOe == 8'h00 && portBLinesOe == 8'h00)
        else $error("reset state not reached");
    dir_write_a: assert property (regWr && addr[1:0] == 2'h1 |=> portALinesOe == $past(dataIn))
        else $error("direction write lost");
    out_write_a: assert property (regWr && addr[1:0] == 2'h2 |=> portBLinesOut == $past(dataIn))
        else $error("output write lost");
    dir_readback_a: assert property (acc && readNotWrite && ramSelectN && addr[2:0] == 3'h3 |=> dataOut == $past(portBLinesOe))
        else $error("direction read wrong");
    ram_isolate_a: assert property (acc && !ramSelectN |=> $stable(portALinesOe) && $stable(portBLinesOut))
        else $error("memory access touched a port");
    irq_drain_a: assert property (irqReqNOe |-> irqReqNOut == 1'b0)
        else $error("request line not pulled low");
    flag_pad_a: assert property (acc && readNotWrite && ramSelectN && addr[2] && addr[0] |=> dataOut[5:0] == 6'h00)
        else $error("flag read padding not zero");
endmodule

// [pit_cpu.sv]
`timescale 1ns/1ps
// processor side: one strobed access per call, launched just after a rising edge
module pit_cpu (
    input  wire logic       sys_clk,
    output logic            busStrobe,
    output logic            chipSelectOne,
    output logic            chipSelectTwoN,
    output logic            ramSelectN,
    output logic            readNotWrite,
    output logic [6:0]      addr,
    output logic [7:0]      dataIn,
    input  wire logic [7:0] dataOut,
    input  wire logic       dataOe
);
    // idle bus at time zero
    initial {busStrobe, chipSelectOne, chipSelectTwoN, ramSelectN, readNotWrite, addr, dataIn} = '0;

    // sel is {select one, select two low, register select low}; answer is caught in its only cycle
    task automatic access(input logic [2:0] sel, input logic rnw, input logic [6:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        #1;
        {chipSelectOne, chipSelectTwoN, ramSelectN} = sel;
        readNotWrite = rnw;
        addr = a;
        dataIn = d;
        busStrobe = 1'b1;
        @(posedge sys_clk);
        #1;
        busStrobe = 1'b0;
        chipSelectOne = 1'b0;
        // released lines flip so stale values never pass for real ones
        addr = ~a;
        dataIn = ~d;
        q = (dataOe === 1'b1) ? dataOut : 8'hxx;
    endtask
endmodule

// [pit_top_tb.sv]
`timescale 1ns/1ps
module pit_top_tb;
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic       busStrobe, chipSelectOne, chipSelectTwoN, ramSelectN, readNotWrite, dataOe, irqReqNOut, irqReqNOe;
    logic [6:0] addr;
    logic [7:0] dataIn, dataOut, portALinesIn, portALinesOut, portALinesOe, q;
    logic [7:0] portBLinesIn, portBLinesOut, portBLinesOe;
    logic [7:0] extA = 8'h33;
    logic [7:0] extB = 8'h55;
    int         mismatches = 0;
    int         checks_done = 0;

    // port A pins follow the drive; every B line is loaded hard so pins never show the drive
    assign portALinesIn = (portALinesOut & portALinesOe) | (extA & ~portALinesOe);
    assign portBLinesIn = extB;

    pit_top pit_top_inst (.sys_clk, .srst, .busStrobe, .chipSelectOne, .chipSelectTwoN, .ramSelectN,
        .readNotWrite, .addr, .dataIn, .dataOut, .dataOe, .portALinesIn, .portALinesOut, .portALinesOe,
        .portBLinesIn, .portBLinesOut, .portBLinesOe, .irqReqNOut, .irqReqNOe);
    pit_cpu pit_cpu_inst (.sys_clk, .busStrobe, .chipSelectOne, .chipSelectTwoN, .ramSelectN,
        .readNotWrite, .addr, .dataIn, .dataOut, .dataOe);

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        pit_cpu_inst.access(3'b101, 1'b0, a, d, q);
    endtask

    task automatic rd(input logic [6:0] a);
        pit_cpu_inst.access(3'b101, 1'b1, a, 8'h00, q);
    endtask

    task automatic t_reset();
        check("port a dir", 8'h00, portALinesOe);
        check("port b dir", 8'h00, portBLinesOe);
        rd(7'h05);
    endtask

    task automatic t_ports();
        wr(7'h01, 8'hf0);
        wr(7'h00, 8'ha5);
        wr(7'h03, 8'h0f);
        wr(7'h02, 8'h3c);
        check("port a drive", 8'ha0, portALinesOut & portALinesOe);
        check("port b dir", 8'h0f, portBLinesOe);
        // pins need the synchroniser to settle
        repeat (6) @(posedge sys_clk);
        rd(7'h00);
        check("port a read", 8'ha3, q);
        rd(7'h02);
        check("port b read", 8'h5c, q);
        rd(7'h03);
        check("port b dir read", 8'h0f, q);
        pit_cpu_inst.access(3'b001, 1'b0, 7'h02, 8'hff, q);
        pit_cpu_inst.access(3'b111, 1'b0, 7'h02, 8'hff, q);
        check("port b deselected", 8'h3c, portBLinesOut);
        pit_cpu_inst.access(3'b100, 1'b0, 7'h2a, 8'h5a, q);
        pit_cpu_inst.access(3'b100, 1'b0, 7'h2b, 8'hc3, q);
        pit_cpu_inst.access(3'b100, 1'b1, 7'h2a, 8'h00, q);
        check("ram read", 8'h5a, q);
        wr(7'h01, 8'h00);
    endtask

    task automatic t_timer();
        int div [4] = '{1, 8, 64, 1024};
        int n;
        for (int p = 0; p < 4; p++) begin
            wr(7'h14 | 7'(p), 8'h03);
            // the first step lands one clock after the load, whatever the prescale
            rd(7'h04);
            check("count early", 8'h02, q);
            n = 0;
            // each flag poll takes two clocks, so the span is known to a few clocks
            do begin
                rd(7'h05);
                n++;
            end while (q[7] !== 1'b1 && n < 2000);
            check("timeout span", 8'h01, {7'h00, (2 * n + 6 >= 3 * div[p]) && (2 * n <= 3 * div[p] + 6)});
            rd(7'h04);
            check("count after timeout", 8'hff, q | 8'h07);
            rd(7'h05);
            check("timer flag cleared", 8'h00, q & 8'h80);
            check("irq held off", 8'h00, {7'h00, irqReqNOe});
        end
        // count of one at divide by one: the next timer read is taken in the timeout clock
        wr(7'h14, 8'h01);
        rd(7'h04);
        check("count at timeout", 8'h00, q);
        rd(7'h05);
        check("flag kept at timeout", 8'h80, q & 8'h80);
    endtask

    task automatic t_irq();
        wr(7'h1c, 8'h01);
        repeat (300) @(posedge sys_clk);
        check("irq asserted", 8'h01, {7'h00, irqReqNOe});
        rd(7'h04);
        check("count limit", 8'h01, q);
        rd(7'h05);
        check("irq released", 8'h00, {7'h00, irqReqNOe});
    endtask

    task automatic t_edge();
        wr(7'h07, 8'h00);
        rd(7'h05);
        extA[7] = 1'b1;
        repeat (8) @(posedge sys_clk);
        check("edge irq", 8'h01, {7'h00, irqReqNOe});
        rd(7'h05);
        check("edge flag", 8'h40, q & 8'h40);
        rd(7'h05);
        check("edge flag cleared", 8'h00, q & 8'h40);
        extA[7] = 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(7'h05);
        check("wrong edge ignored", 8'h00, q & 8'h40);
        wr(7'h04, 8'h00);
        wr(7'h00, 8'h80);
        wr(7'h01, 8'h80);
        repeat (6) @(posedge sys_clk);
        wr(7'h00, 8'h00);
        repeat (8) @(posedge sys_clk);
        check("irq off", 8'h00, {7'h00, irqReqNOe});
        rd(7'h05);
        check("output edge flag", 8'h40, q & 8'h40);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence after three reset cycles
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 srst = 1'b0;
        t_reset();
        t_ports();
        t_timer();
        t_irq();
        t_edge();
        print_verdict();
    end

    // watchdog: the run needs well under ten thousand clocks
    initial begin
        #(30000 * 4);
        mismatches++;
        print_verdict();
    end
endmodule

bind pit_top pit_asserts pit_asserts_inst (.sys_clk, .srst, .busStrobe, .chipSelectOne, .chipSelectTwoN,
    .ramSelectN, .readNotWrite, .addr, .dataIn, .dataOut, .dataOe, .portALinesOe, .portBLinesOut,
    .portBLinesOe, .irqReqNOut, .irqReqNOe);
